// ===== bench/two_wire_wiper_command_slave_test.sv
// Self-checking bench for the two-wire wiper command slave
module two_wire_wiper_command_slave_test
  import tww_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] ID    = {DEV_TYPE_CODE, STRAP, 1'b0};
  logic         clk, rst, scl, sda, sda_out, sda_oe_n, busy;
  logic         lock_n = 1'b1;
  logic [255:0] tap;
  logic [7:0]   pos, rd;
  logic [2:0]   ak;
  int           n_errors = 0;
  int           n_compared = 0;
  tww_slave #(.NV_CYCLES(400)) tww_slave_inst (
    .MCLK(clk), .SYS_RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .WRITE_LOCK_N(lock_n), .ADDR_STRAP_PINS(STRAP), .WIPER_TAP(tap), .WIPER_POSITION(pos), .NV_BUSY(busy));
  tww_master tww_master_inst (.clk(clk), .scl(scl), .sda(sda), .dev_out(sda_out), .dev_oe_n(sda_oe_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  // md 0 sends a data byte, 1 reads one, 2 stops after the instruction
  task automatic cmd(input logic [7:0] id, input logic [7:0] ins, input logic [7:0] wd, input int md);
    ak = 3'h1;
    tww_master_inst.start();
    tww_master_inst.put(id, ak[2]);
    tww_master_inst.put(ins, ak[1]);
    if (md == 0) tww_master_inst.put(wd, ak[0]);
    if (md == 1) tww_master_inst.get(rd);
    tww_master_inst.stop();
  endtask : cmd
  task automatic idle_wait();
    repeat (1000) begin
      if (busy === 1'b0) break;
      @(negedge clk);
    end
    chk("busy end", {7'h00, busy}, 8'h00);
  endtask : idle_wait
  task automatic nv_wait();
    chk("busy", {7'h00, busy}, 8'h01);
    cmd(ID, {OP_RD_WIPER, 4'h0}, 8'h00, 1);
    chk("poll", {5'h00, ak}, 8'h01);
    idle_wait();
  endtask : nv_wait
  task automatic t_wiper();
    chk("boot", pos, 8'h00);
    cmd(ID, {OP_WR_WIPER, 4'h0}, 8'hC6, 0);
    chk("acks", {5'h00, ak}, 8'h07);
    chk("pos", pos, 8'hC6);
    chk("tap", {7'h00, tap[8'hC6]}, 8'h01);
    cmd(ID, {OP_RD_WIPER, 4'h0}, 8'h00, 1);
    chk("rd", rd, 8'hC6);
  endtask : t_wiper
  task automatic t_refuse();
    cmd({~DEV_TYPE_CODE, STRAP, 1'b0}, {OP_WR_WIPER, 4'h0}, 8'h11, 0);
    chk("type", {5'h00, ak}, 8'h00);
    cmd({DEV_TYPE_CODE, ~STRAP, 1'b0}, {OP_WR_WIPER, 4'h0}, 8'h22, 0);
    chk("strap", {5'h00, ak}, 8'h00);
    chk("kept", pos, 8'hC6);
  endtask : t_refuse
  // Register i of bank 3-i holds 0x30+i
  task automatic t_setting();
    for (int i = 0; i < 4; i++) begin
      cmd(ID, {OP_WR_SET, i[1:0], 2'(3 - i)}, 8'h30 + 8'(i), 0);
      nv_wait();
    end
    for (int i = 0; i < 4; i++) begin
      cmd(ID, {OP_RD_SET, i[1:0], 2'(3 - i)}, 8'h00, 1);
      chk("set", rd, 8'h30 + 8'(i));
    end
  endtask : t_setting
  task automatic t_lock();
    lock_n = 1'b0;
    cmd(ID, {OP_WR_SET, 4'h3}, 8'hEE, 0);
    idle_wait();
    lock_n = 1'b1;
    cmd(ID, {OP_RD_SET, 4'h3}, 8'h00, 1);
    chk("locked", rd, 8'h30);
  endtask : t_lock
  task automatic t_xfer();
    cmd(ID, {OP_SET2WIPER, 4'hC}, 8'h00, 2);
    chk("to pos", pos, 8'h33);
    cmd(ID, {OP_SET2WIPER, 4'h9}, 8'h00, 2);
    chk("bank1", pos, 8'h33);
    cmd(ID, {OP_WR_WIPER, 4'h0}, 8'hFE, 0);
    cmd(ID, {OP_WIPER2SET, 4'h4}, 8'h00, 2);
    nv_wait();
    cmd(ID, {OP_RD_SET, 4'h4}, 8'h00, 1);
    chk("from pos", rd, 8'hFE);
  endtask : t_xfer
  // The closing stop clocks once more, so position is judged before it
  task automatic t_step();
    tww_master_inst.start();
    tww_master_inst.put(ID, ak[2]);
    tww_master_inst.put({OP_STEP, 4'h0}, ak[1]);
    repeat (2) tww_master_inst.tick(1'b1, ak[0]);
    chk("top", pos, 8'hFF);
    repeat (3) tww_master_inst.tick(1'b0, ak[0]);
    chk("down", pos, 8'hFC);
    tww_master_inst.stop();
  endtask : t_step
  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_wiper();
    t_refuse();
    t_setting();
    t_lock();
    t_xfer();
    t_step();
    print_verdict();
  end
  initial begin
    repeat (60000) @(negedge clk);
    n_errors++;
    print_verdict();
  end
endmodule : two_wire_wiper_command_slave_test

// ===== bench/tww_master.sv
// Bus master model: serial clock and open-drain data with pull-up
module tww_master (
  input  wire logic clk,
  output logic      scl,
  output logic      sda,
  input  wire logic dev_out,
  input  wire logic dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_sda = 1'b1;
  initial scl = 1'b1;
  // Pull-up wins unless a party pulls low
  assign sda = m_sda & (dev_oe_n | dev_out);
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // Four clocks per phase make a 400 ns serial clock; data moves mid-low
  task automatic tick(input logic b, output logic r);
    scl = 1'b0;
    w(2);
    m_sda = b;
    w(2);
    scl = 1'b1;
    w(3);
    r = sda;
    w(1);
  endtask : tick
  task automatic start();
    w(8);
    m_sda = 1'b0;
    w(8);
  endtask : start
  task automatic stop();
    logic r;
    tick(1'b0, r);
    m_sda = 1'b1;
    w(8);
  endtask : stop
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) tick(b[i], r);
    tick(1'b1, r);
    ack = ~r;
  endtask : put
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) tick(1'b1, d[i]);
    tick(1'b1, r);
  endtask : get
endmodule : tww_master

// ===== bench/tww_slave_props.sv
// Port-level assertions for the two-wire wiper slave
module tww_slave_props #(
  parameter int NV_CYCLES = 20
) (
  input wire logic         MCLK,
  input wire logic         SYS_RST,
  input wire logic         SCL,
  input wire logic         SDA_IN,
  input wire logic         SDA_OUT,
  input wire logic         SDA_OE_N,
  input wire logic         WRITE_LOCK_N,
  input wire logic [2:0]   ADDR_STRAP_PINS,
  input wire logic [255:0] WIPER_TAP,
  input wire logic [7:0]   WIPER_POSITION,
  input wire logic         NV_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  // Eight cycles of slack over the NV_CYCLES busy time, counted from the rise of NV_BUSY
  localparam int NV_MAX = NV_CYCLES + 8;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_tap_onehot; $onehot(WIPER_TAP); endproperty
  a_tap_onehot: assert property (p_tap_onehot) else $error("tap not one-hot");
  property p_tap_match; $stable(WIPER_POSITION) |-> WIPER_TAP == (256'h1 << WIPER_POSITION); endproperty
  a_tap_match: assert property (p_tap_match) else $error("tap differs from position");
  property p_oe_scl_low; $changed(SDA_OE_N) |-> !$past(SCL); endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
  property p_ack_hold; $rose(SCL) && !SDA_OE_N |-> !SDA_OE_N [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low data not held while clock high");
  property p_busy_no_ack; NV_BUSY |-> SDA_OE_N; endproperty
  a_busy_no_ack: assert property (p_busy_no_ack) else $error("line pulled while busy");
  property p_busy_on_stop; $rose(NV_BUSY) |-> SCL && SDA_IN; endproperty
  a_busy_on_stop: assert property (p_busy_on_stop) else $error("write cycle not at stop");
  property p_busy_bound; $rose(NV_BUSY) |-> ##[1:NV_MAX] !NV_BUSY; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write cycle too long");
  property p_boot; $fell(SYS_RST) |-> ##2 WIPER_POSITION == 8'h00; endproperty
  a_boot: assert property (p_boot) else $error("boot position wrong");
endmodule : tww_slave_props
bind tww_slave tww_slave_props #(.NV_CYCLES(NV_CYCLES)) tww_slave_props_inst (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .WRITE_LOCK_N(WRITE_LOCK_N), .ADDR_STRAP_PINS(ADDR_STRAP_PINS), .WIPER_TAP(WIPER_TAP),
  .WIPER_POSITION(WIPER_POSITION), .NV_BUSY(NV_BUSY));

// ===== inc/tww_pkg.sv
// Package of constants and types for the two-wire wiper command slave
// How it works
// - Wiper value decodes to exactly one tap
// - Write-lock low blocks all non-volatile writes
// - Data changes only while clock low
// - Start condition opens every command; watched continuously
// - Transmitter releases line; receiver acknowledges ninth clock
// - Acknowledge identification, instruction and data bytes
// - Stop starts write cycle; address unacknowledged meanwhile
// - Upper identification nibble must match type code
// - Low address bits must match strap inputs
// - Sixteen setting registers in four banks
// - Wiper transfers allowed only with bank zero
// - Opcode 1001 returns wiper position
// - Opcode 1010 loads wiper position
// - Opcode 1011 returns selected setting register
// - Opcode 1100 writes selected setting register
// - Opcode 1101 copies bank-0 register to wiper
// - Opcode 1110 copies wiper to bank-0 register
// - Opcode 0010 enables stepping until transaction ends
// - Step up on data high, down on low
// - Reset loads wiper from default setting register
// - Non-volatile write completes within 10 ms
package tww_pkg;

  localparam logic [3:0] DEV_TYPE_CODE = 4'h6;  // Arbitrary type code value
  localparam logic [3:0] OP_RD_WIPER   = 4'h9;
  localparam logic [3:0] OP_WR_WIPER   = 4'hA;
  localparam logic [3:0] OP_RD_SET     = 4'hB;
  localparam logic [3:0] OP_WR_SET     = 4'hC;
  localparam logic [3:0] OP_SET2WIPER  = 4'hD;
  localparam logic [3:0] OP_WIPER2SET  = 4'hE;
  localparam logic [3:0] OP_STEP       = 4'h2;

  localparam int CLK_HZ        = 20_000_000;
  localparam int NV_WRITE_US   = 5_000;  // Typical cycle, below the 10 ms ceiling
  localparam int NV_WRITE_CYC  = (CLK_HZ / 1_000_000) * NV_WRITE_US;
  localparam logic [7:0] WIPER_MAX    = 8'hFF;
  localparam logic [7:0] WIPER_MIN    = 8'h00;
  localparam logic [7:0] SETTING_RST  = 8'h00;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_RX    = 7'b000_0010,
    ST_ACK   = 7'b000_0100,
    ST_TX    = 7'b000_1000,
    ST_MACK  = 7'b001_0000,
    ST_STEP  = 7'b010_0000,
    ST_BOOT  = 7'b100_0000
  } tww_state_t;

endpackage : tww_pkg

// ===== verilog/tww_slave.sv
// Two-wire slave, command decoder, wiper register and setting store
module tww_slave
  import tww_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYC
) (
  input  wire logic         MCLK,
  input  wire logic         SYS_RST,
  input  wire logic         SCL,
  input  wire logic         SDA_IN,
  output logic              SDA_OUT,
  output logic              SDA_OE_N,
  input  wire logic         WRITE_LOCK_N,
  input  wire logic [2:0]   ADDR_STRAP_PINS,
  output logic [255:0]      WIPER_TAP,
  output logic [7:0]        WIPER_POSITION,
  output logic              NV_BUSY
);

  logic scl_s;
  logic sda_s;

  tww_sync u_scl (
    .MCLK      (MCLK),
    .SYS_RST   (SYS_RST),
    .pin_in    (SCL),
    .level_out (scl_s)
  );

  tww_sync u_sda (
    .MCLK      (MCLK),
    .SYS_RST   (SYS_RST),
    .pin_in    (SDA_IN),
    .level_out (sda_s)
  );

  typedef struct packed {
    tww_state_t  state;
    logic        scl_d;
    logic        sda_d;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic [1:0]  byte_no;
    logic [7:0]  instr;
    logic [7:0]  wiper;
    logic        drive_low;
    logic        pend_nv;
    logic [3:0]  pend_idx;
    logic [7:0]  pend_val;
    logic        busy;
    logic [31:0] nv_cnt;
    logic [3:0]  nv_idx;
    logic [7:0]  nv_val;
    logic        is_read;
    logic        sda_out;
    logic        sda_oe_n;
    logic [255:0] tap;
  } tww_regs_t;

  tww_regs_t   r_ff;
  tww_regs_t   nxt_r;
  logic [7:0]  setting_reg [16];  // Four banks of four
  logic        nv_commit;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] sel_idx;
  logic [3:0] opc;
  logic       bank0;
  logic [7:0] rx_byte;

  assign scl_rise   = scl_s && !r_ff.scl_d;
  assign scl_fall   = !scl_s && r_ff.scl_d;
  assign start_seen = scl_s && r_ff.scl_d && r_ff.sda_d && !sda_s;
  assign stop_seen  = scl_s && r_ff.scl_d && !r_ff.sda_d && sda_s;
  assign opc        = r_ff.instr[7:4];
  // Index is bank*4 + register: bank bits high, register bits below them
  assign sel_idx    = {r_ff.instr[1:0], r_ff.instr[3:2]};
  assign bank0      = (r_ff.instr[1:0] == 2'b00);
  assign rx_byte    = {r_ff.shift[6:0], sda_s};

  // Setting store commits only at the end of the internal write cycle
  assign nv_commit  = r_ff.busy && (r_ff.nv_cnt == 32'(NV_CYCLES - 1));

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < 16; i++) begin
        setting_reg[i] <= SETTING_RST;
      end
    end else if (nv_commit) begin
      setting_reg[r_ff.nv_idx] <= r_ff.nv_val;
    end
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.scl_d = scl_s;
    nxt_r.sda_d = sda_s;

    // Internal write cycle timer
    if (r_ff.busy) begin
      nxt_r.nv_cnt = r_ff.nv_cnt + 32'h0000_0001;
      if (nv_commit) begin
        nxt_r.busy   = 1'b0;
        nxt_r.nv_cnt = 32'h0000_0000;
      end
    end

    unique case (r_ff.state)
      ST_BOOT: begin
        nxt_r.wiper = setting_reg[0];
        nxt_r.state = ST_IDLE;
      end
      ST_IDLE: begin
        nxt_r.drive_low = 1'b0;
      end
      ST_RX: begin
        if (scl_rise) begin
          nxt_r.shift  = rx_byte;
          nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
        end
        if (scl_fall && r_ff.bitcnt == 4'h8) begin
          nxt_r.state  = ST_IDLE;
          nxt_r.bitcnt = 4'h0;
          unique case (r_ff.byte_no)
            2'd0: begin
              if (r_ff.shift[7:4] == DEV_TYPE_CODE
                  && r_ff.shift[3:1] == ADDR_STRAP_PINS
                  && !r_ff.busy) begin
                nxt_r.drive_low = 1'b1;
                nxt_r.state     = ST_ACK;
              end
            end
            2'd1: begin
              nxt_r.instr     = r_ff.shift;
              nxt_r.drive_low = 1'b1;
              nxt_r.state     = ST_ACK;
            end
            default: begin
              nxt_r.drive_low = 1'b1;
              nxt_r.state     = ST_ACK;
              if (opc == OP_WR_WIPER) begin
                nxt_r.wiper = r_ff.shift;
              end else if (opc == OP_WR_SET) begin
                nxt_r.pend_nv  = WRITE_LOCK_N;
                nxt_r.pend_idx = sel_idx;
                nxt_r.pend_val = r_ff.shift;
              end
            end
          endcase
        end
      end
      ST_ACK: begin
        // Acknowledge held through the ninth clock, released on its falling edge
        if (scl_fall) begin
          nxt_r.drive_low = 1'b0;
          nxt_r.byte_no   = r_ff.byte_no + 2'd1;
          nxt_r.state     = ST_RX;
          if (r_ff.byte_no == 2'd1) begin
            nxt_r.is_read = 1'b0;
            if (opc == OP_RD_WIPER) begin
              nxt_r.shift   = r_ff.wiper;
              nxt_r.is_read = 1'b1;
            end else if (opc == OP_RD_SET) begin
              nxt_r.shift   = setting_reg[sel_idx];
              nxt_r.is_read = 1'b1;
            end else if (opc == OP_SET2WIPER && bank0) begin
              nxt_r.wiper = setting_reg[sel_idx];
              nxt_r.state = ST_IDLE;
            end else if (opc == OP_WIPER2SET && bank0) begin
              nxt_r.pend_nv  = WRITE_LOCK_N;
              nxt_r.pend_idx = sel_idx;
              nxt_r.pend_val = r_ff.wiper;
              nxt_r.state    = ST_IDLE;
            end else if (opc == OP_STEP) begin
              nxt_r.state = ST_STEP;
            end else if (opc == OP_SET2WIPER || opc == OP_WIPER2SET) begin
              nxt_r.state = ST_IDLE;
            end
            if (nxt_r.is_read) begin
              nxt_r.state     = ST_TX;
              nxt_r.drive_low = !nxt_r.shift[7];
              nxt_r.bitcnt    = 4'h1;
            end
          end else if (r_ff.byte_no == 2'd2) begin
            nxt_r.state = ST_IDLE;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r_ff.bitcnt == 4'h8) begin
            nxt_r.drive_low = 1'b0;
            nxt_r.state     = ST_MACK;
          end else begin
            nxt_r.shift     = {r_ff.shift[6:0], 1'b0};
            nxt_r.drive_low = !r_ff.shift[6];
            nxt_r.bitcnt    = r_ff.bitcnt + 4'h1;
          end
        end
      end
      ST_MACK: begin
        if (scl_fall) begin
          nxt_r.state = ST_IDLE;
        end
      end
      ST_STEP: begin
        if (scl_rise) begin
          if (sda_s && r_ff.wiper != WIPER_MAX) begin
            nxt_r.wiper = r_ff.wiper + 8'h01;
          end else if (!sda_s && r_ff.wiper != WIPER_MIN) begin
            nxt_r.wiper = r_ff.wiper - 8'h01;
          end
        end
      end
      default: begin
        nxt_r.state = ST_IDLE;
      end
    endcase

    // Stop launches a pending write; start restarts framing from any state except ST_BOOT
    if (r_ff.state != ST_BOOT) begin
      if (stop_seen) begin
        nxt_r.state     = ST_IDLE;
        nxt_r.drive_low = 1'b0;
        if (r_ff.pend_nv) begin
          nxt_r.busy    = 1'b1;
          nxt_r.nv_cnt  = 32'h0000_0000;
          nxt_r.nv_idx  = r_ff.pend_idx;
          nxt_r.nv_val  = r_ff.pend_val;
          nxt_r.pend_nv = 1'b0;
        end
      end else if (start_seen) begin
        nxt_r.state     = ST_RX;
        nxt_r.bitcnt    = 4'h0;
        nxt_r.byte_no   = 2'd0;
        nxt_r.drive_low = 1'b0;
        nxt_r.pend_nv   = 1'b0;
      end
    end

    nxt_r.sda_out  = 1'b0;
    nxt_r.sda_oe_n = !nxt_r.drive_low;  // Open drain: only ever pulls low
    nxt_r.tap      = 256'h0;
    nxt_r.tap[nxt_r.wiper] = 1'b1;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r_ff          <= '0;
      r_ff.state    <= ST_BOOT;
      r_ff.scl_d    <= 1'b1;
      r_ff.sda_d    <= 1'b1;
      r_ff.sda_oe_n <= 1'b1;
      r_ff.tap      <= 256'h1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign SDA_OUT        = r_ff.sda_out;
  assign SDA_OE_N       = r_ff.sda_oe_n;
  assign WIPER_TAP      = r_ff.tap;
  assign WIPER_POSITION = r_ff.wiper;
  assign NV_BUSY        = r_ff.busy;

endmodule : tww_slave

// ===== verilog/tww_sync.sv
// Three-stage pin synchroniser with agreement filter
module tww_sync (
  input  wire logic MCLK,
  input  wire logic SYS_RST,
  input  wire logic pin_in,
  output logic      level_out
);
  typedef struct packed {
    logic [2:0] sh;
    logic       held;
  } tww_sync_t;

  tww_sync_t r_ff;
  tww_sync_t nxt_r;

  // Stage one feeds stage two only; level moves when stages two and three agree
  // Agreed level leaves unregistered so an answer fits inside a short low phase
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.sh   = {r_ff.sh[1:0], pin_in};
    level_out  = (r_ff.sh[1] == r_ff.sh[2]) ? r_ff.sh[2] : r_ff.held;
    nxt_r.held = level_out;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      r_ff <= '1;  // Bus lines idle high
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule : tww_sync
